// ==== ife_pkg.sv ====
package ife_pkg;

    // ==============================
    // widths
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 4;

    // ==============================
    // register offsets
    localparam logic [3:0] OFF_FLAGS_THREE  = 4'h0;
    localparam logic [3:0] OFF_FLAGS_FOUR   = 4'h1;
    localparam logic [3:0] OFF_ENABLES_ZERO = 4'h2;

    // ==============================
    // field positions, flag register three
    localparam int unsigned RTC_CALENDAR_FLAG   = 14;
    localparam int unsigned DMA_CH5_DONE_FLAG   = 13;
    localparam int unsigned AUDIO_IF_EVENT_FLAG = 12;
    localparam int unsigned AUDIO_IF_ERROR_FLAG = 11;

    // ==============================
    // field positions, flag register four
    localparam int unsigned DAC_LEFT_FLAG       = 15;
    localparam int unsigned DAC_RIGHT_FLAG      = 14;
    localparam int unsigned CAN_TX_REQUEST_FLAG = 6;
    localparam int unsigned DMA_CH7_DONE_FLAG   = 5;
    localparam int unsigned DMA_CH6_DONE_FLAG   = 4;
    localparam int unsigned CRC_GEN_FLAG        = 3;
    localparam int unsigned UART_TWO_ERROR_FLAG = 2;
    localparam int unsigned UART_ONE_ERROR_FLAG = 1;

    // ==============================
    // field positions, enable register zero
    localparam int unsigned DMA_CH1_DONE_ENABLE    = 14;
    localparam int unsigned ADC_ONE_DONE_ENABLE    = 13;
    localparam int unsigned UART_ONE_TX_ENABLE     = 12;
    localparam int unsigned UART_ONE_RX_ENABLE     = 11;
    localparam int unsigned SPI_ONE_EVENT_ENABLE   = 10;
    localparam int unsigned SPI_ONE_ERROR_ENABLE   = 9;
    localparam int unsigned TIMER_THREE_ENABLE     = 8;
    localparam int unsigned TIMER_TWO_ENABLE       = 7;
    localparam int unsigned OUT_COMPARE_TWO_ENABLE = 6;
    localparam int unsigned IN_CAPTURE_TWO_ENABLE  = 5;
    localparam int unsigned DMA_CH0_DONE_ENABLE    = 4;
    localparam int unsigned TIMER_ONE_ENABLE       = 3;
    localparam int unsigned OUT_COMPARE_ONE_ENABLE = 2;
    localparam int unsigned IN_CAPTURE_ONE_ENABLE  = 1;
    localparam int unsigned EXT_IRQ_ZERO_ENABLE    = 0;

    // ==============================
    // implemented bit masks and reset values
    localparam logic [15:0] IMPL_FLAGS_THREE  = 16'h7800;
    localparam logic [15:0] IMPL_FLAGS_FOUR   = 16'hC07E;
    localparam logic [15:0] IMPL_ENABLES_ZERO = 16'h7FFF;
    localparam logic [15:0] CAN_BITS_FOUR     = 16'h0040;
    localparam logic [15:0] DAC_BITS_FOUR     = 16'hC000;
    localparam logic [15:0] RST_VAL           = 16'h0000;

    // ==============================
    // carriers
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ife_bus_s;

    typedef struct packed {
        logic [DATA_W-1:0] three;
        logic [DATA_W-1:0] four;
    } ife_flags_s;

endpackage : ife_pkg

// ==== ife_bit_reg.sv ====
`timescale 1ns/1ns
module ife_bit_reg #(
    parameter logic [15:0] IMPL = 16'hFFFF
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_wr,
    input  wire logic [15:0] i_wdata,
    input  wire logic [15:0] i_set,
    output logic      [15:0] o_q
);

    typedef struct packed {
        logic [15:0] q;
    } ife_bit_state_s;

    ife_bit_state_s st_r;
    ife_bit_state_s st_nxt;
    logic [15:0]    bit_nxt;

    // ==============================
    // per bit next value
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_bit
            if (IMPL[g]) begin : g_impl
                // hardware set wins over a software clear in the same cycle
                assign bit_nxt[g] = (i_wr ? i_wdata[g] : st_r.q[g]) | i_set[g];
            end else begin : g_unimpl
                assign bit_nxt[g] = 1'b0;
            end
        end
    endgenerate

    always_comb begin
        st_nxt   = st_r;
        st_nxt.q = bit_nxt;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_q = st_r.q;

endmodule : ife_bit_reg

// ==== ife_irq_regs.sv ====
`timescale 1ns/1ns
module ife_irq_regs #(
    parameter bit HAS_CAN = 1'b1,
    parameter bit HAS_DAC = 1'b1
) (
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst,
    input  wire logic [3:0]             i_addr,
    input  wire logic [15:0]            i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    input  wire ife_pkg::ife_flags_s    i_req,
    input  wire ife_pkg::ife_flags_s    i_en_ext,
    input  wire logic [15:0]            i_flags_zero,
    output logic      [15:0]            o_rdata,
    output ife_pkg::ife_flags_s         o_flags,
    output logic      [15:0]            o_enables_zero,
    output ife_pkg::ife_flags_s         o_fwd,
    output logic      [15:0]            o_fwd_zero
);

    // ==============================
    // variant masks
    localparam logic [15:0] MASK_THREE = ife_pkg::IMPL_FLAGS_THREE;
    localparam logic [15:0] MASK_FOUR  = ife_pkg::IMPL_FLAGS_FOUR
        & ~(HAS_CAN ? ife_pkg::RST_VAL : ife_pkg::CAN_BITS_FOUR)
        & ~(HAS_DAC ? ife_pkg::RST_VAL : ife_pkg::DAC_BITS_FOUR);

    typedef struct packed {
        logic [15:0]         rdata;
        ife_pkg::ife_flags_s fwd;
        logic [15:0]         fwd_zero;
    } ife_top_state_s;

    ife_pkg::ife_bus_s bus;
    ife_top_state_s    st_r;
    ife_top_state_s    st_nxt;
    logic [15:0]       flags_three;
    logic [15:0]       flags_four;
    logic [15:0]       enables_zero;
    logic              wr_three;
    logic              wr_four;
    logic              wr_zero;

    assign bus      = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign wr_three = bus.wr && (bus.addr == ife_pkg::OFF_FLAGS_THREE);
    assign wr_four  = bus.wr && (bus.addr == ife_pkg::OFF_FLAGS_FOUR);
    assign wr_zero  = bus.wr && (bus.addr == ife_pkg::OFF_ENABLES_ZERO);

    // ==============================
    // register cells
    ife_bit_reg #(.IMPL(MASK_THREE)) u_flags_three (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_wr    (wr_three),
        .i_wdata (bus.wdata),
        .i_set   (i_req.three),
        .o_q     (flags_three)
    );

    ife_bit_reg #(.IMPL(MASK_FOUR)) u_flags_four (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_wr    (wr_four),
        .i_wdata (bus.wdata),
        .i_set   (i_req.four),
        .o_q     (flags_four)
    );

    ife_bit_reg #(.IMPL(ife_pkg::IMPL_ENABLES_ZERO)) u_enables_zero (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_wr    (wr_zero),
        .i_wdata (bus.wdata),
        .i_set   (ife_pkg::RST_VAL),
        .o_q     (enables_zero)
    );

    // ==============================
    // read path and forwarding
    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = ife_pkg::RST_VAL;
        if (bus.rd) begin
            case (bus.addr)
                ife_pkg::OFF_FLAGS_THREE:  st_nxt.rdata = flags_three;
                ife_pkg::OFF_FLAGS_FOUR:   st_nxt.rdata = flags_four;
                ife_pkg::OFF_ENABLES_ZERO: st_nxt.rdata = enables_zero;
                default:                   st_nxt.rdata = ife_pkg::RST_VAL;
            endcase
        end
        st_nxt.fwd.three = flags_three & i_en_ext.three;
        st_nxt.fwd.four  = flags_four & i_en_ext.four;
        st_nxt.fwd_zero  = i_flags_zero & enables_zero;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==============================
    // outputs
    assign o_rdata        = st_r.rdata;
    assign o_flags.three  = flags_three;
    assign o_flags.four   = flags_four;
    assign o_enables_zero = enables_zero;
    assign o_fwd          = st_r.fwd;
    assign o_fwd_zero     = st_r.fwd_zero;

endmodule : ife_irq_regs

// ==== ife_src_model.sv ====
`timescale 1ns/1ns
module ife_src_model (
    input  wire logic                i_mclk,
    input  wire logic                i_fire,
    input  wire ife_pkg::ife_flags_s i_which,
    output ife_pkg::ife_flags_s      o_req
);
    // ==============================
    // request pulses one cycle behind i_fire and as wide as it, low between them
    always_ff @(posedge i_mclk) begin
        o_req <= i_fire ? i_which : 32'h0;
    end
endmodule : ife_src_model

// ==== ife_irq_regs_properties.sv ====
`timescale 1ns/1ns
module ife_chk (
    input wire logic                i_mclk,
    input wire logic                i_rst,
    input wire logic [3:0]          i_addr,
    input wire logic [15:0]         i_wdata,
    input wire logic                i_wr,
    input wire logic                i_rd,
    input wire ife_pkg::ife_flags_s i_req,
    input wire ife_pkg::ife_flags_s i_en_ext,
    input wire logic [15:0]         i_flags_zero,
    input wire logic [15:0]         o_rdata,
    input wire ife_pkg::ife_flags_s o_flags,
    input wire logic [15:0]         o_enables_zero,
    input wire ife_pkg::ife_flags_s o_fwd,
    input wire logic [15:0]         o_fwd_zero
);
    // ==============================
    // properties
    localparam logic [31:0] IMPL = {ife_pkg::IMPL_FLAGS_THREE, ife_pkg::IMPL_FLAGS_FOUR};
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_en_wr;
        i_wr && i_addr == ife_pkg::OFF_ENABLES_ZERO;
    endsequence
    sequence s_rd_four;
        i_rd && i_addr == ife_pkg::OFF_FLAGS_FOUR;
    endsequence
    chk_unimpl_zero: assert property ((o_flags & ~IMPL) == 32'h0 && !o_enables_zero[15])
        else $error("unimplemented bit set");
    chk_flag_sets: assert property (1 |=> (o_flags & $past(i_req) & IMPL) == ($past(i_req) & IMPL))
        else $error("request did not set flag");
    chk_flag_holds: assert property (!(i_wr && i_addr <= 4'h1) |=>
        (o_flags & $past(o_flags)) == $past(o_flags)) else $error("flag lost without write");
    chk_en_write: assert property (s_en_wr |=> o_enables_zero == ($past(i_wdata) & 16'h7FFF))
        else $error("enable write not stored");
    chk_en_hold: assert property (!(i_wr && i_addr == ife_pkg::OFF_ENABLES_ZERO) |=>
        $stable(o_enables_zero))
        else $error("enable changed without write");
    chk_fwd_ext: assert property (1 |=> o_fwd == ($past(o_flags) & $past(i_en_ext)))
        else $error("forward mismatch");
    chk_fwd_zero: assert property (1 |=> o_fwd_zero == ($past(i_flags_zero) & $past(o_enables_zero)))
        else $error("enable gating mismatch");
    chk_rd_four: assert property (s_rd_four |=> o_rdata == $past(o_flags.four))
        else $error("read data mismatch");
    chk_rd_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data outside read");
endmodule : ife_chk
bind ife_irq_regs ife_chk u_ife_chk (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_req,
    .i_en_ext, .i_flags_zero, .o_rdata, .o_flags, .o_enables_zero, .o_fwd, .o_fwd_zero);

// ==== ife_irq_regs_tb.sv ====
`timescale 1ns/1ns
module ife_irq_regs_tb;
    // ==============================
    // bench
    logic                i_mclk = 1'b0;
    logic                i_rst = 1'b1;
    logic [3:0]          i_addr = 4'h0;
    logic [15:0]         i_wdata = 16'h0000;
    logic                i_wr = 1'b0;
    logic                i_rd = 1'b0;
    logic                fire = 1'b0;
    logic [15:0]         i_flags_zero = 16'h0000;
    logic [15:0]         o_rdata, o_enables_zero, o_fwd_zero;
    logic [15:0]         msk [3] = '{16'h7800, 16'hC07E, 16'h7FFF};
    logic [31:0]         e;
    ife_pkg::ife_flags_s which = 32'h0;
    ife_pkg::ife_flags_s i_en_ext = 32'hAAAA_5555;
    ife_pkg::ife_flags_s i_req, o_flags, o_fwd;
    int                  errors = 0;
    int                  cmp_count = 0;
    ife_src_model u_ife_src_model (.i_mclk, .i_fire(fire), .i_which(which), .o_req(i_req));
    ife_irq_regs u_ife_irq_regs (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_req,
        .i_en_ext, .i_flags_zero, .o_rdata, .o_flags, .o_enables_zero, .o_fwd, .o_fwd_zero);
    initial forever #50 i_mclk = ~i_mclk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1 check(o_rdata, exp, "o_rdata");
    endtask : rd_reg
    task automatic give_verdict;
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic t_rw;
        for (int a = 0; a < 3; a++) begin
            wr_reg(4'(a), 16'hFFFF);
            wr_reg(4'hF, 16'h0000);
            rd_reg(4'(a), msk[a]);
            rd_reg(4'h3 + 4'(a), 16'h0000);
            wr_reg(4'(a), 16'h0000);
            rd_reg(4'(a), 16'h0000);
        end
    endtask : t_rw
    task automatic t_flags;
        for (int b = 0; b < 32; b++) begin
            e = (32'h1 << b) & {msk[0], msk[1]};
            @(posedge i_mclk);
            fire  <= 1'b1;
            which <= 32'h1 << b;
            @(posedge i_mclk);
            fire  <= 1'b0;
            repeat (3) @(posedge i_mclk);
            #1;
            check(o_fwd.three, e[31:16] & 16'hAAAA, "o_fwd.three");
            check(o_fwd.four, e[15:0] & 16'h5555, "o_fwd.four");
            rd_reg(4'h0, e[31:16]);
            rd_reg(4'h1, e[15:0]);
            wr_reg(b < 16 ? 4'h1 : 4'h0, 16'h0000);
        end
    endtask : t_flags
    task automatic t_fwd_zero;
        for (int k = 0; k < 2; k++) begin
            i_flags_zero <= k ? 16'hF0F0 : 16'hFFFF;
            wr_reg(4'h2, k ? 16'h8F33 : 16'h0000);
            repeat (2) @(posedge i_mclk);
            #1 check(o_fwd_zero, k ? 16'h0030 : 16'h0000, "o_fwd_zero");
        end
    endtask : t_fwd_zero
    initial begin
        repeat (12) @(posedge i_mclk);
        check(o_flags.three | o_flags.four | o_enables_zero, 16'h0000, "reset");
        i_rst <= 1'b0;
        for (int a = 0; a < 4; a++) rd_reg(a == 3 ? 4'hF : 4'(a), 16'h0000);
        t_rw();
        t_flags();
        t_fwd_zero();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        errors++;
        give_verdict();
    end
endmodule : ife_irq_regs_tb
